// ---- include/imsp_params.svh ----
// register indices, lane layout, reset values and bus constants of the mask and soft-post block
`ifndef IMSP_PARAMS_SVH
`define IMSP_PARAMS_SVH

`define IMSP_ADDR_W          10
`define IMSP_DATA_W          32
`define IMSP_IDX_W           8

`define IMSP_IDX_CLEAR_CORE  8'hDA
`define IMSP_IDX_CLEAR_LOWT  8'hDB
`define IMSP_IDX_CLEAR_HIGH  8'hDC
`define IMSP_IDX_MASK_HIGH   8'hDE
`define IMSP_IDX_MASK_LOWT   8'hDF
`define IMSP_IDX_MASK_CORE   8'hE0
`define IMSP_IDX_SOFT_EN     8'hE1

`define IMSP_SRC_W           22
`define IMSP_HIGH_W          6
`define IMSP_CORE_LSB        0
`define IMSP_LOWT_LSB        8
`define IMSP_HIGH_LSB        16

`define IMSP_SOFT_EN_BIT     0
`define IMSP_RST_MASK        8'h00
`define IMSP_RST_MASK_HIGH   6'h00
`define IMSP_RST_SOFT_EN     1'b0
`define IMSP_RST_RDATA       32'h0000_0000
`define IMSP_UNMAPPED_RDATA  8'h00

`endif

// ---- include/imsp_pkg.sv ----
// types shared by the mask and soft-post block
package imsp_pkg;
`include "imsp_params.svh"

   typedef logic [`IMSP_SRC_W-1:0]  imsp_src_t;
   typedef logic [`IMSP_IDX_W-1:0]  imsp_idx_t;
   typedef logic [7:0]              imsp_byte_t;

   typedef enum logic [1:0]
   {
      IMSP_BUS_IDLE = 2'b01,
      IMSP_BUS_ACK  = 2'b10
   } imsp_bus_e;

endpackage

// ---- include/imsp_src_if.sv ----
// per-source vectors between the register file and the posted/pending bank
`timescale 1ns/10ps
interface imsp_src_if;
   import imsp_pkg::*;

   imsp_src_t hw_post;
   imsp_src_t sw_post;
   imsp_src_t clear;
   imsp_src_t mask;
   imsp_src_t posted;
   imsp_src_t pending;

   modport regs
   (
      output hw_post,
      output sw_post,
      output clear,
      output mask,
      input  posted,
      input  pending
   );

   modport bank
   (
      input  hw_post,
      input  sw_post,
      input  clear,
      input  mask,
      output posted,
      output pending
   );
endinterface

// ---- logic/imsp_post_bank.sv ----
// posted and pending state of every interrupt source
`timescale 1ns/10ps
module imsp_post_bank
(
   input  wire logic clk,
   input  wire logic rst_b,
   imsp_src_if.bank  src
);
   import imsp_pkg::*;

   imsp_src_t next_posted;

   ////////////////////////////////////////////////////////////////////////////////
   // a new post wins over a clear in the same cycle, so no event is lost
   always_comb
   begin
      next_posted = src.hw_post | src.sw_post | (src.posted & ~src.clear);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         src.posted <= '0;
      else
         src.posted <= next_posted;
   end

   // mask gates only posted to pending; posted itself never sees it
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         src.pending <= '0;
      else
         src.pending <= src.posted & src.mask;
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_masked_still_posts : assert property
      ((|src.hw_post) |=> ((src.posted & $past(src.hw_post)) == $past(src.hw_post)))
      else $error("hardware post lost");
   a_zero_mask_blocks : assert property
      ((src.pending & ~$past(src.mask)) == '0)
      else $error("masked source became pending");
   a_pend_needs_post : assert property
      (((src.pending & ~$past(src.posted)) == '0) and
       ((($past(src.posted) & $past(src.mask)) & ~src.pending) == '0))
      else $error("pending does not follow posted and mask");
endmodule

// ---- logic/imsp_top.sv ----
// interrupt mask, posted-clear and software-post register block with an Avalon-MM slave
//
// Overview of operation
// - mask zero masks, one unmasks, per source
// - masked sources still record posted interrupts
// - posted becomes pending only while unmasked
// - core mask: i2c sleep spi gpio timer0 touch analog vmon
// - usb-low mask: endpoints 3-0, sof, busreset, timers
// - usb-high mask: wake, endpoints 8-4, 7:6 reserved
// - soft enable bit 0 allows software posting
// - enable low: write zero clears posted interrupt
// - enable high: write zero changes nothing
// - enable high: write one posts an interrupt
// - enable low: write one changes nothing
// - clear register read shows posted sources
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "imsp_params.svh"
module imsp_top
(
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire logic [`IMSP_ADDR_W-1:0]  avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [`IMSP_DATA_W-1:0]  avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic      [`IMSP_DATA_W-1:0]  avs_readdata,
   output logic                          avs_waitrequest,
   input  wire imsp_pkg::imsp_src_t      src_post,
   output imsp_pkg::imsp_src_t           posted,
   output imsp_pkg::imsp_src_t           pending,
   output logic                          soft_post_enable
);
   import imsp_pkg::*;

   imsp_bus_e                 bus_state;
   imsp_idx_t                 idx;
   imsp_byte_t                wbyte;
   logic                      wr_acc;
   logic                      rd_acc;
   imsp_byte_t                source_mask_core_peripherals;
   imsp_byte_t                source_mask_usb_low_timers;
   logic [`IMSP_HIGH_W-1:0]   source_mask_usb_high;
   imsp_src_t                 clear_sel;
   imsp_src_t                 clear_val;
   imsp_src_t                 next_clear;
   imsp_src_t                 next_sw_post;

   imsp_src_if src ();

   ////////////////////////////////////////////////////////////////////////////////
   // places a byte on the lane of one clear register, zero elsewhere
   function automatic imsp_src_t place_lane
   (
      input imsp_idx_t  at,
      input imsp_byte_t val
   );
      imsp_src_t v;
      v = '0;
      case (at)
         `IMSP_IDX_CLEAR_CORE : v[`IMSP_LOWT_LSB-1:`IMSP_CORE_LSB] = val;
         `IMSP_IDX_CLEAR_LOWT : v[`IMSP_HIGH_LSB-1:`IMSP_LOWT_LSB] = val;
         `IMSP_IDX_CLEAR_HIGH : v[`IMSP_SRC_W-1:`IMSP_HIGH_LSB] = val[`IMSP_HIGH_W-1:0];
         default              : v = '0;
      endcase
      return v;
   endfunction

   // register value seen by a read at one index
   function automatic imsp_byte_t read_value
   (
      input imsp_idx_t at
   );
      imsp_byte_t v;
      v = `IMSP_UNMAPPED_RDATA;
      case (at)
         `IMSP_IDX_CLEAR_CORE : v = src.posted[`IMSP_LOWT_LSB-1:`IMSP_CORE_LSB];
         `IMSP_IDX_CLEAR_LOWT : v = src.posted[`IMSP_HIGH_LSB-1:`IMSP_LOWT_LSB];
         `IMSP_IDX_CLEAR_HIGH : v = {2'b00, src.posted[`IMSP_SRC_W-1:`IMSP_HIGH_LSB]};
         `IMSP_IDX_MASK_HIGH  : v = {2'b00, source_mask_usb_high};
         `IMSP_IDX_MASK_LOWT  : v = source_mask_usb_low_timers;
         `IMSP_IDX_MASK_CORE  : v = source_mask_core_peripherals;
         `IMSP_IDX_SOFT_EN    : v = {7'h00, soft_post_enable};
         default              : v = `IMSP_UNMAPPED_RDATA;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, then a single-cycle answer
   assign idx    = avs_address[`IMSP_ADDR_W-1:2];
   assign wbyte  = avs_writedata[7:0];
   assign wr_acc = (bus_state == IMSP_BUS_ACK) && avs_write && avs_byteenable[0];
   assign rd_acc = (bus_state == IMSP_BUS_ACK) && avs_read;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         bus_state       <= IMSP_BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         unique case (bus_state)
            IMSP_BUS_IDLE :
            begin
               if (avs_read || avs_write)
               begin
                  bus_state       <= IMSP_BUS_ACK;
                  avs_waitrequest <= 1'b0;
               end
            end
            IMSP_BUS_ACK :
            begin
               bus_state       <= IMSP_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // read data captured one edge ahead, so it stands while waitrequest is low
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         avs_readdata <= `IMSP_RST_RDATA;
      else if ((bus_state == IMSP_BUS_IDLE) && avs_read)
         avs_readdata <= {24'h00_0000, read_value(idx)};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mask and enable registers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         source_mask_core_peripherals <= `IMSP_RST_MASK;
      else if (wr_acc && (idx == `IMSP_IDX_MASK_CORE))
         source_mask_core_peripherals <= wbyte;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         source_mask_usb_low_timers <= `IMSP_RST_MASK;
      else if (wr_acc && (idx == `IMSP_IDX_MASK_LOWT))
         source_mask_usb_low_timers <= wbyte;
   end

   // reserved bits 7:6 are not stored and read back zero
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         source_mask_usb_high <= `IMSP_RST_MASK_HIGH;
      else if (wr_acc && (idx == `IMSP_IDX_MASK_HIGH))
         source_mask_usb_high <= wbyte[`IMSP_HIGH_W-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         soft_post_enable <= `IMSP_RST_SOFT_EN;
      else if (wr_acc && (idx == `IMSP_IDX_SOFT_EN))
         soft_post_enable <= wbyte[`IMSP_SOFT_EN_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // clear-register writes: meaning of each bit flips with the soft enable
   always_comb
   begin
      clear_sel    = '0;
      clear_val    = '0;
      next_clear   = '0;
      next_sw_post = '0;
      if (wr_acc)
      begin
         clear_sel = place_lane(idx, 8'hFF);
         clear_val = place_lane(idx, wbyte);
         if (soft_post_enable)
            next_sw_post = clear_sel & clear_val;
         else
            next_clear = clear_sel & ~clear_val;
      end
   end

   assign src.hw_post = src_post;
   assign src.sw_post = next_sw_post;
   assign src.clear   = next_clear;
   assign src.mask    = {source_mask_usb_high, source_mask_usb_low_timers,
                         source_mask_core_peripherals};

   imsp_post_bank u_bank
   (
      .clk   (clk),
      .rst_b (rst_b),
      .src   (src)
   );

   assign posted  = src.posted;
   assign pending = src.pending;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_request;
      (avs_read || avs_write) && avs_waitrequest && (bus_state == IMSP_BUS_IDLE);
   endsequence

   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   sequence s_clear_write;
      wr_acc && !soft_post_enable && (place_lane(idx, 8'hFF) != '0);
   endsequence

   sequence s_post_write;
      wr_acc && soft_post_enable && (place_lane(idx, 8'hFF) != '0);
   endsequence

   sequence s_unmapped_read;
      rd_acc && !(idx inside {`IMSP_IDX_CLEAR_CORE, `IMSP_IDX_CLEAR_LOWT, `IMSP_IDX_CLEAR_HIGH,
         `IMSP_IDX_MASK_HIGH, `IMSP_IDX_MASK_LOWT, `IMSP_IDX_MASK_CORE, `IMSP_IDX_SOFT_EN});
   endsequence

   // mask and enable writes must never disturb what the sources posted
   sequence s_other_write;
      wr_acc && (place_lane(idx, 8'hFF) == '0);
   endsequence

   a_bus_answer_once : assert property (s_request |=> s_answer) else $error("bus answer not one cycle after request");

   a_mask_core_write : assert property
      (wr_acc && (idx == `IMSP_IDX_MASK_CORE) |=> (src.mask[7:0] == $past(wbyte)))
      else $error("core mask not written");

   a_mask_lowt_write : assert property
      (wr_acc && (idx == `IMSP_IDX_MASK_LOWT) |=> (src.mask[15:8] == $past(wbyte)))
      else $error("usb low mask not written");

   a_mask_high_write : assert property
      (wr_acc && (idx == `IMSP_IDX_MASK_HIGH) |=> (src.mask[21:16] == $past(wbyte[5:0])))
      else $error("usb high mask not written");

   a_mask_high_resv : assert property
      (rd_acc && (idx == `IMSP_IDX_MASK_HIGH) |-> (avs_readdata[7:6] == 2'b00))
      else $error("reserved mask bits read nonzero");

   a_read_mask_core : assert property
      (rd_acc && (idx == `IMSP_IDX_MASK_CORE) |-> (avs_readdata[7:0] == $past(src.mask[7:0])))
      else $error("core mask read wrong");

   a_read_mask_lowt : assert property
      (rd_acc && (idx == `IMSP_IDX_MASK_LOWT) |-> (avs_readdata[7:0] == $past(src.mask[15:8])))
      else $error("usb low mask read wrong");

   a_read_mask_high : assert property
      (rd_acc && (idx == `IMSP_IDX_MASK_HIGH) |-> (avs_readdata[7:0] == {2'h0, $past(src.mask[21:16])}))
      else $error("usb high mask read wrong");

   a_soft_en_write : assert property
      (wr_acc && (idx == `IMSP_IDX_SOFT_EN) |=> (soft_post_enable == $past(wbyte[0])))
      else $error("soft enable not written");

   a_read_soft_en : assert property
      (rd_acc && (idx == `IMSP_IDX_SOFT_EN) |-> (avs_readdata[7:0] == {7'h00, $past(soft_post_enable)}))
      else $error("soft enable read wrong");

   a_soft_en_hold : assert property
      (!(wr_acc && (idx == `IMSP_IDX_SOFT_EN)) |=> $stable(soft_post_enable))
      else $error("soft enable changed without a write");

   a_masks_hold : assert property
      (!wr_acc |=> $stable(src.mask))
      else $error("mask changed without a write");

   a_zero_clears : assert property
      (s_clear_write |=> ((src.posted & $past(next_clear) & ~$past(src.hw_post)) == '0))
      else $error("posted not cleared");

   a_one_no_post : assert property
      (s_clear_write |=> ((src.posted & ~$past(src.posted) & ~$past(src.hw_post)) == '0))
      else $error("write one posted while disabled");

   a_soft_posts : assert property
      (s_post_write |=> ((src.posted & $past(clear_sel & clear_val)) == $past(clear_sel & clear_val)))
      else $error("software post lost");

   a_zero_keeps : assert property
      (s_post_write |=> ((($past(src.posted) & $past(clear_sel)) & ~src.posted) == '0))
      else $error("write zero cleared while enabled");

   a_other_keeps : assert property
      (s_other_write |=> (src.posted == ($past(src.posted) | $past(src.hw_post))))
      else $error("non-clear write touched posted");

   a_post_steady : assert property
      ((!wr_acc && (src.hw_post == '0)) |=> $stable(src.posted))
      else $error("posted changed with no post and no write");

   a_read_posted : assert property
      (rd_acc && (idx == `IMSP_IDX_CLEAR_LOWT) |-> (avs_readdata[7:0] == $past(src.posted[15:8])))
      else $error("clear read does not show posted");

   a_read_clear_core : assert property
      (rd_acc && (idx == `IMSP_IDX_CLEAR_CORE) |-> (avs_readdata[7:0] == $past(src.posted[7:0])))
      else $error("core clear read does not show posted");

   a_read_clear_high : assert property
      (rd_acc && (idx == `IMSP_IDX_CLEAR_HIGH) |-> (avs_readdata[7:0] == {2'h0, $past(src.posted[21:16])}))
      else $error("usb high clear read does not show posted");

   a_unmapped_zero : assert property
      (s_unmapped_read |-> (avs_readdata == 32'h0000_0000))
      else $error("unmapped read not zero");

   a_rdata_upper : assert property
      (avs_readdata[31:8] == 24'h00_0000)
      else $error("read data upper bits nonzero");

   a_read_capture : assert property
      (!((bus_state == IMSP_BUS_IDLE) && avs_read) |=> $stable(avs_readdata))
      else $error("read data moved without a read");

   a_wait_one_low : assert property
      (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_wait_idle_high : assert property
      ((bus_state == IMSP_BUS_IDLE) |-> avs_waitrequest)
      else $error("waitrequest low while idle");

   a_idle_after_ack : assert property
      ((bus_state == IMSP_BUS_ACK) |=> (bus_state == IMSP_BUS_IDLE))
      else $error("bus answer not single cycle");

   a_reset_masked : assert property
      ($rose(rst_b) |-> ((src.mask == '0) && !soft_post_enable))
      else $error("reset state wrong");

   a_reset_clean : assert property
      ($rose(rst_b) |-> ((src.posted == '0) && (src.pending == '0)))
      else $error("posted or pending set after reset");
endmodule

// ---- verif/imsp_src_model.sv ----
// source side model: pulses hardware post lines on command
`timescale 1ns/10ps
module imsp_src_model
   import imsp_pkg::*;
(
   input  wire logic           clk,
   output imsp_pkg::imsp_src_t src_post
);
   initial src_post = '0;
   // one-cycle pulse only; a held line would re-post after every clear
   task automatic fire(input imsp_src_t vec);
      @(posedge clk);
      src_post <= vec;
      @(posedge clk);
      src_post <= '0;
   endtask
endmodule

// ---- verif/imsp_top_tb.sv ----
// self-checking bench of the mask and soft-post register block
`timescale 1ns/10ps
`include "imsp_params.svh"
module imsp_top_tb;
   import imsp_pkg::*;
   logic             clk;
   logic             rst_b;
   logic [9:0]       avs_address;
   logic             avs_read;
   logic             avs_write;
   logic [31:0]      avs_writedata;
   logic [31:0]      avs_readdata;
   logic             avs_waitrequest;
   imsp_src_t        src_post;
   imsp_src_t        posted;
   imsp_src_t        pending;
   logic             soft_post_enable;
   int               fail_count;
   int               n_compared;
   imsp_byte_t       rd;
////////////////////////////////////////////////////////////////
   imsp_top dut_u
   (
      .clk              (clk),
      .rst_b            (rst_b),
      .avs_address      (avs_address),
      .avs_read         (avs_read),
      .avs_write        (avs_write),
      .avs_writedata    (avs_writedata),
      .avs_byteenable   (4'hF),
      .avs_readdata     (avs_readdata),
      .avs_waitrequest  (avs_waitrequest),
      .src_post         (src_post),
      .posted           (posted),
      .pending          (pending),
      .soft_post_enable (soft_post_enable)
   );
   imsp_src_model src_u
   (
      .clk      (clk),
      .src_post (src_post)
   );
////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // one access; held until waitrequest is seen low at a rising edge
   task automatic acc(input logic wr, input imsp_idx_t idx, input imsp_byte_t wd, output imsp_byte_t r);
      int n;
      n = 0;
      r = 8'h00;
      @(posedge clk);
      avs_address   <= {idx, 2'b00};
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= {24'h000000, wd};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0)
      begin
         fail_count++;
         stop_test();
      end
      r = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
////////////////////////////////////////////////////////////////
   task automatic t_reset();
      acc(0, `IMSP_IDX_MASK_HIGH, 8'h00, rd);
      chk(rd, 8'h00);
      acc(0, `IMSP_IDX_MASK_LOWT, 8'h00, rd);
      chk(rd, 8'h00);
      acc(0, `IMSP_IDX_MASK_CORE, 8'h00, rd);
      chk(rd, 8'h00);
      acc(0, `IMSP_IDX_SOFT_EN, 8'h00, rd);
      chk(rd, 8'h00);
      chk(soft_post_enable, 1'b0);
   endtask
   task automatic t_mask();
      src_u.fire('1);
      settle();
      chk(posted, 22'h3FFFFF);
      chk(pending, 22'h000000);
      acc(1, `IMSP_IDX_MASK_CORE, 8'h81, rd);
      acc(1, `IMSP_IDX_MASK_LOWT, 8'h12, rd);
      acc(1, `IMSP_IDX_MASK_HIGH, 8'h21, rd);
      settle();
      chk(pending, {6'h21, 8'h12, 8'h81});
      acc(0, `IMSP_IDX_MASK_CORE, 8'h00, rd);
      chk(rd, 8'h81);
      acc(0, `IMSP_IDX_MASK_LOWT, 8'h00, rd);
      chk(rd, 8'h12);
      acc(0, `IMSP_IDX_MASK_HIGH, 8'h00, rd);
      chk(rd, 8'h21);
   endtask
   task automatic t_clear_off();
      acc(1, `IMSP_IDX_CLEAR_HIGH, 8'h36, rd);
      settle();
      chk(posted, {6'h36, 8'hFF, 8'hFF});
      chk(pending, {6'h20, 8'h12, 8'h81});
      acc(0, `IMSP_IDX_CLEAR_HIGH, 8'h00, rd);
      chk(rd, 8'h36);
      acc(1, `IMSP_IDX_CLEAR_LOWT, 8'h00, rd);
      acc(1, `IMSP_IDX_CLEAR_LOWT, 8'hFF, rd);
      settle();
      chk(posted[15:8], 8'h00);
   endtask
   task automatic t_soft_on();
      acc(1, `IMSP_IDX_SOFT_EN, 8'h01, rd);
      acc(0, `IMSP_IDX_SOFT_EN, 8'h00, rd);
      chk(rd, 8'h01);
      chk(soft_post_enable, 1'b1);
      acc(1, `IMSP_IDX_CLEAR_LOWT, 8'h5A, rd);
      acc(1, `IMSP_IDX_CLEAR_CORE, 8'h00, rd);
      settle();
      chk(posted, {6'h36, 8'h5A, 8'hFF});
      acc(0, `IMSP_IDX_CLEAR_LOWT, 8'h00, rd);
      chk(rd, 8'h5A);
      acc(0, `IMSP_IDX_CLEAR_CORE, 8'h00, rd);
      chk(rd, 8'hFF);
      // unmapped place answers with zero
      acc(0, 8'h10, 8'h00, rd);
      chk(rd, 8'h00);
   endtask
   // second reset in mid-run, with masks set and soft posting enabled
   task automatic t_mid_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      chk(pending, 22'h000000);
   endtask
////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      fail_count    = 0;
      n_compared    = 0;
      rst_b         = 1'b0;
      avs_address   = '0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = '0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_mask();
      t_clear_off();
      t_soft_on();
      t_mid_reset();
      stop_test();
   end
endmodule
